// ---- sfr_defines.svh ----
// Constants for the serial flash command front end.
// Assumes inclusion by bare name; definitions only.
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
`define SFR_OP_NORMAL_READ    8'h03
`define SFR_OP_FAST_READ      8'h0B
`define SFR_OP_DUAL_OUT_READ  8'h3B
`define SFR_OP_QUAD_OUT_READ  8'h6B
`define SFR_OP_DDR_FAST_READ  8'h0D
`define SFR_OP_DUAL_IO_READ   8'hBB
`define SFR_OP_DUAL_IO_DDR    8'hBD
`define SFR_OP_QUAD_IO_READ   8'hEB
`define SFR_OP_QUAD_IO_DDR    8'hED
`define SFR_OP_UNIQUE_ID_READ 8'h4B
`define SFR_OP_PARAM_TBL_READ 8'h5A
`define SFR_OP_INFO_ROW_READ  8'h68
`define SFR_OP_SET_READ_PARAM 8'hC0
`define SFR_OP_SET_WRITE_LAT  8'h06
`define SFR_OP_CLR_WRITE_LAT  8'h04
`define SFR_OP_WRITE_STATUS   8'h01
`define SFR_OP_WRITE_FUNC     8'h42
`define SFR_OP_QPI_ENTER      8'h35
`define SFR_OP_QPI_EXIT       8'hF5
`define SFR_OP_PAGE_PROG      8'h02
`define SFR_OP_QUAD_PROG_A    8'h32
`define SFR_OP_QUAD_PROG_B    8'h38
`define SFR_OP_SECT_ERASE_Q   8'h20
`define SFR_OP_SECT_ERASE_S   8'hD7
`define SFR_OP_BLK32_ERASE    8'h52
`define SFR_OP_BLK64_ERASE    8'hD8
`define SFR_OP_CHIP_ERASE_A   8'hC7
`define SFR_OP_CHIP_ERASE_B   8'h60
`define SFR_OP_INFO_ROW_PROG  8'h62
`define SFR_OP_INFO_ROW_ERASE 8'h64
`define SFR_RP_DEFAULT        8'hE0
`define SFR_RP_WRAP           2
`define SFR_SR_RESET          8'h00
`define SFR_SR_STATUS_WRITE_DISABLE           7
`define SFR_SR_QE             6
`define SFR_FR_TBS            1
`define SFR_CYC_W             11
`define SFR_OPC_SPI           11'h008
`define SFR_OPC_QPI           11'h002
`define SFR_ADDR_BITS         11'h018
`define SFR_DUMMY_FIXED       4'h8
`define SFR_DUMMY_DDR_SPI     4'h4
`define SFR_DUMMY_QUAD_TBL    16'hA846
`define SFR_DUMMY_DDR_TBL     16'h5423
`define SFR_DUMMY_DUAL_TBL    16'h8844
`define SFR_DUMMY_DUALDDR_TBL 16'h4422
`define SFR_DRIVE_TBL         32'h48603210
`define SFR_BURST_MIN         8'h08
`define SFR_NUM_BLOCKS        8'h80
`endif

// ---- sfr_pkg.sv ----
// Types shared by the flash command front end.
// Assumes nothing beyond a SystemVerilog compiler.
package sfr_pkg;
  typedef enum logic [1:0] {SFR_L1, SFR_L2, SFR_L4} sfr_lanes_t;
  typedef enum logic [1:0] {SFR_PH_OPC, SFR_PH_ADDR, SFR_PH_DATA} sfr_phase_t;
endpackage

// ---- sfr_lane_if.sv ----
// Carrier between the link sequencer and the lane shifter.
// Assumes both ends run on the serial clock.
`timescale 1ns/1ps
interface sfr_lane_if;
  import sfr_pkg::*;
  sfr_lanes_t  lanes;
  logic        dtr;
  logic [3:0]  io_in;
  logic [31:0] sh_d;
  logic [31:0] peek;
  modport shifter (input lanes, dtr, io_in, output sh_d, peek);
  modport seq (output lanes, dtr, io_in, input sh_d, peek);
endinterface

// ---- sfr_lane_shifter.sv ----
// Input shift register for the serial link, one to four lanes.
// Assumes the serial clock only toggles while chip select is low.
`timescale 1ns/1ps
module sfr_lane_shifter
  import sfr_pkg::*;
(
  // Link
  input wire logic sck,
  input wire logic cs_b,
  // Sequencer side
  sfr_lane_if.shifter lk
);
  logic [31:0] sh_q;
  logic [3:0]  fall_q;
  logic        pair_q;

  function automatic logic [31:0] shl(input logic [31:0] w, input sfr_lanes_t l,
                                      input logic [3:0] b);
    case (l)
      SFR_L1:  shl = {w[30:0], b[0]};
      SFR_L2:  shl = {w[29:0], b[1:0]};
      SFR_L4:  shl = {w[27:0], b};
      default: shl = w;
    endcase
  endfunction

  // Falling-edge sample, merged at the next rising edge
  always_ff @(negedge sck)
  begin
    fall_q <= lk.io_in;
  end

  always_ff @(posedge sck or posedge cs_b)
  begin
    if (cs_b)
      pair_q <= 1'b0;
    else
      pair_q <= lk.dtr;
  end

  always_ff @(posedge sck)
  begin
    sh_q <= lk.sh_d;
  end

  // Newest bits enter at the bottom, so the first bit ends up most significant
  assign lk.peek = pair_q ? shl(sh_q, lk.lanes, fall_q) : sh_q;
  assign lk.sh_d = shl(lk.peek, lk.lanes, lk.io_in);
endmodule

// ---- sfr_cmd_top.sv ----
// Command front end of a serial NOR flash: opcode framing, read dummy
// timing, burst wrap, drive strength and write gating.
// Assumes the array answers rd_byte combinationally from rd_addr and that
// chip select stays high for at least four core clocks between frames.
`timescale 1ns/1ps
`include "sfr_defines.svh"
module sfr_cmd_top
  import sfr_pkg::*;
#(
  parameter int ARRAY_AW = 23
)
(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Serial link
  input  wire logic        sck,
  input  wire logic        cs_b,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic        wp_b,
  // Array read port, serial clock domain
  output logic      [23:0] rd_addr,
  input  wire logic [7:0]  rd_byte,
  // Program and erase requests
  output logic             pe_req,
  output logic      [7:0]  pe_op,
  output logic      [23:0] pe_addr,
  output logic             wr_ignored,
  // Configuration and status
  output logic             write_enable_latch,
  output logic             status_write_disable,
  output logic             quad_io_enable,
  output logic             protect_level_msb,
  output logic      [2:0]  protect_level_low,
  output logic             top_bottom_select,
  output logic             qpi_mode,
  output logic      [7:0]  read_params,
  output logic      [3:0]  drive_eighths,
  output logic             drive_reserved,
  output logic      [7:0]  burst_bytes
);
  localparam int CW = `SFR_CYC_W;

  sfr_lane_if lk ();

  sfr_lane_shifter u_shift (
    .sck  (sck),
    .cs_b (cs_b),
    .lk   (lk)
  );

  // Core-domain state that the link reads as quasi-static words
  logic [7:0] rp_q;
  logic       qpi_q;

  function automatic logic is_dtr(input logic [7:0] op);
    is_dtr = (op == `SFR_OP_DDR_FAST_READ) || (op == `SFR_OP_DUAL_IO_DDR) ||
             (op == `SFR_OP_QUAD_IO_DDR);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    case (op)
      `SFR_OP_NORMAL_READ, `SFR_OP_FAST_READ, `SFR_OP_DUAL_OUT_READ,
      `SFR_OP_QUAD_OUT_READ, `SFR_OP_DDR_FAST_READ, `SFR_OP_DUAL_IO_READ,
      `SFR_OP_DUAL_IO_DDR, `SFR_OP_QUAD_IO_READ, `SFR_OP_QUAD_IO_DDR,
      `SFR_OP_UNIQUE_ID_READ, `SFR_OP_PARAM_TBL_READ, `SFR_OP_INFO_ROW_READ:
        is_read = 1'b1;
      default:
        is_read = 1'b0;
    endcase
  endfunction

  function automatic sfr_lanes_t addr_lanes(input logic [7:0] op, input logic q);
    if (q)
      addr_lanes = SFR_L4;
    else if (op == `SFR_OP_DUAL_IO_READ || op == `SFR_OP_DUAL_IO_DDR)
      addr_lanes = SFR_L2;
    else if (op == `SFR_OP_QUAD_IO_READ || op == `SFR_OP_QUAD_IO_DDR)
      addr_lanes = SFR_L4;
    else
      addr_lanes = SFR_L1;
  endfunction

  function automatic sfr_lanes_t data_lanes(input logic [7:0] op, input logic q);
    case (op)
      `SFR_OP_DUAL_OUT_READ, `SFR_OP_DUAL_IO_READ, `SFR_OP_DUAL_IO_DDR:
        data_lanes = q ? SFR_L4 : SFR_L2;
      `SFR_OP_QUAD_OUT_READ, `SFR_OP_QUAD_IO_READ, `SFR_OP_QUAD_IO_DDR,
      `SFR_OP_QUAD_PROG_A, `SFR_OP_QUAD_PROG_B:
        data_lanes = SFR_L4;
      default:
        data_lanes = q ? SFR_L4 : SFR_L1;
    endcase
  endfunction

  // Dummy cycles per opcode, mode and setting; mode-bit cycles are inside
  function automatic logic [3:0] dummy_fn(input logic [7:0] op, input logic q,
                                          input logic [1:0] ds);
    logic [5:0] i;
    i = {2'b00, ds, 2'b00};
    case (op)
      `SFR_OP_FAST_READ, `SFR_OP_UNIQUE_ID_READ,
      `SFR_OP_PARAM_TBL_READ, `SFR_OP_INFO_ROW_READ:
        dummy_fn = q ? 4'(`SFR_DUMMY_QUAD_TBL >> i) : `SFR_DUMMY_FIXED;
      `SFR_OP_DUAL_OUT_READ, `SFR_OP_QUAD_OUT_READ:
        dummy_fn = `SFR_DUMMY_FIXED;
      `SFR_OP_DDR_FAST_READ:
        dummy_fn = q ? 4'(`SFR_DUMMY_DDR_TBL >> i) : `SFR_DUMMY_DDR_SPI;
      `SFR_OP_QUAD_IO_READ:
        dummy_fn = 4'(`SFR_DUMMY_QUAD_TBL >> i);
      `SFR_OP_QUAD_IO_DDR:
        dummy_fn = 4'(`SFR_DUMMY_DDR_TBL >> i);
      `SFR_OP_DUAL_IO_READ:
        dummy_fn = 4'(`SFR_DUMMY_DUAL_TBL >> i);
      `SFR_OP_DUAL_IO_DDR:
        dummy_fn = 4'(`SFR_DUMMY_DUALDDR_TBL >> i);
      default:
        dummy_fn = 4'h0;
    endcase
  endfunction

  // Next byte address: burst wrap or whole-array wrap
  function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                            input logic [7:0] rp);
    logic [23:0] n;
    logic [23:0] m;
    n = a + 24'h000001;
    m = {16'h0000, (`SFR_BURST_MIN << rp[1:0]) - 8'h01};
    if (rp[`SFR_RP_WRAP])
      wrap_next = (a & ~m) | (n & m);
    else
      wrap_next = n & ((24'h000001 << ARRAY_AW) - 24'h000001);
  endfunction

  // Block protection by level bits and top/bottom select
  function automatic logic prot_hit(input logic [23:0] a, input logic [3:0] lvl,
                                    input logic tb);
    logic [7:0] cnt;
    logic [7:0] blk;
    cnt = (lvl[2:0] == 3'h0) ? 8'h00 : (8'h01 << (lvl[2:0] - 3'h1));
    blk = {1'b0, a[22:16]};
    if (lvl[3])
      prot_hit = 1'b1;
    else if (tb)
      prot_hit = blk < cnt;
    else
      prot_hit = blk >= (`SFR_NUM_BLOCKS - cnt);
  endfunction

  // Serial clock domain
  logic          fresh_q;
  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_e;
  logic [CW-1:0] opc_n;
  logic [CW-1:0] ade;
  logic [CW-1:0] dstart;
  logic [7:0]    op_q;
  logic [7:0]    dat_q;
  logic [23:0]   addr_q;
  logic [7:0]    lrp_q;
  logic [3:0]    dummy_q;
  sfr_phase_t    ph;
  sfr_lanes_t    al;
  sfr_lanes_t    dl;

  // Frame start is marked by chip select, since the serial clock stops
  always_ff @(posedge sck or posedge cs_b)
  begin
    if (cs_b)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  assign cyc_e = fresh_q ? '0 : cyc_q;
  assign opc_n = qpi_q ? `SFR_OPC_QPI : `SFR_OPC_SPI;
  assign al = addr_lanes(op_q, qpi_q);
  assign dl = data_lanes(op_q, qpi_q);
  assign ade = opc_n + (`SFR_ADDR_BITS >> (CW'(al) + CW'(is_dtr(op_q))));
  assign dstart = ade + CW'(dummy_q);

  always_comb
  begin
    if (cyc_e < opc_n)
      ph = SFR_PH_OPC;
    else if (cyc_e < ade)
      ph = SFR_PH_ADDR;
    else
      ph = SFR_PH_DATA;
  end

  always_comb
  begin
    lk.io_in = io_in;
    lk.dtr = 1'b0;
    case (ph)
      SFR_PH_OPC:
        lk.lanes = qpi_q ? SFR_L4 : SFR_L1;
      SFR_PH_ADDR:
      begin
        lk.lanes = al;
        lk.dtr = is_dtr(op_q);
      end
      SFR_PH_DATA:
        lk.lanes = dl;
      default:
        lk.lanes = SFR_L1;
    endcase
  end

  // Cycle count is kept after the frame so the core can judge completeness
  always_ff @(posedge sck)
  begin
    cyc_q <= (cyc_e == '1) ? cyc_e : cyc_e + CW'(1);
  end

  always_ff @(posedge sck)
  begin
    if (cyc_e == opc_n - CW'(1))
    begin
      op_q <= lk.sh_d[7:0];
      lrp_q <= rp_q;
      dummy_q <= dummy_fn(lk.sh_d[7:0], qpi_q, rp_q[4:3]);
    end
  end

  always_ff @(posedge sck)
  begin
    if (cyc_e == (opc_n << 1) - CW'(1))
      dat_q <= lk.sh_d[7:0];
  end

  // DTR address completes on a falling edge, so it is taken one edge later
  always_ff @(posedge sck)
  begin
    if (ph != SFR_PH_OPC && is_dtr(op_q) && cyc_e == ade)
      addr_q <= lk.peek[23:0];
    else if (ph == SFR_PH_ADDR && !is_dtr(op_q) && cyc_e == ade - CW'(1))
      addr_q <= lk.sh_d[23:0];
  end

  // Read data out on falling edges, only once the dummy period is over
  logic        rd_act;
  logic        first_q;
  logic [23:0] nxt_q;
  logic [7:0]  osh_q;
  logic [3:0]  obit_q;
  logic [7:0]  ob;
  logic [3:0]  w;

  assign rd_act = !fresh_q && is_read(op_q) && cyc_q >= dstart;
  assign ob = (obit_q == 4'h0) ? rd_byte : osh_q;
  assign w = (dl == SFR_L4) ? 4'h4 : ((dl == SFR_L2) ? 4'h2 : 4'h1);
  assign rd_addr = first_q ? addr_q : nxt_q;

  always_ff @(negedge sck or posedge cs_b)
  begin
    if (cs_b)
    begin
      io_oe <= 4'h0;
      io_out <= 4'h0;
      osh_q <= 8'h00;
      obit_q <= 4'h0;
      first_q <= 1'b1;
      nxt_q <= 24'h000000;
    end
    else if (!rd_act)
    begin
      io_oe <= 4'h0;
      first_q <= 1'b1;
    end
    else
    begin
      case (dl)
        SFR_L4:
        begin
          io_out <= ob[7:4];
          io_oe <= 4'hF;
        end
        SFR_L2:
        begin
          io_out <= {2'b00, ob[7:6]};
          io_oe <= 4'h3;
        end
        default:
        begin
          io_out <= {2'b00, ob[7], 1'b0};
          io_oe <= 4'h2;
        end
      endcase
      osh_q <= ob << w;
      obit_q <= ((obit_q == 4'h0) ? 4'h8 : obit_q) - w;
      if (obit_q == 4'h0)
      begin
        nxt_q <= wrap_next(rd_addr, lrp_q);
        first_q <= 1'b0;
      end
    end
  end

  // Core domain
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic cs_rise;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= cs_b;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= wp_b;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Link words are stable here: the serial clock has stopped
  assign cs_rise = cs_s2_q && !cs_s3_q;

  logic [CW-1:0] c_opc;
  logic [CW-1:0] c_ade;
  logic          only_op;
  logic          has_dat;
  logic          has_adr;
  logic          pe_try;
  logic          pe_prot;
  logic          sr_try;
  logic          fr_try;
  logic          wr_try;
  logic          sr_lock;
  logic [7:0]    sr_q;

  assign c_opc = qpi_q ? `SFR_OPC_QPI : `SFR_OPC_SPI;
  assign only_op = cyc_q == c_opc;
  assign has_dat = cyc_q >= (c_opc << 1);
  assign c_ade = c_opc + (qpi_q ? (`SFR_ADDR_BITS >> 2) : `SFR_ADDR_BITS);
  assign has_adr = cyc_q >= c_ade;
  assign sr_try = op_q == `SFR_OP_WRITE_STATUS && has_dat;
  assign fr_try = op_q == `SFR_OP_WRITE_FUNC && has_dat;
  assign sr_lock = sr_q[`SFR_SR_STATUS_WRITE_DISABLE] && !wp_s2_q;

  always_comb
  begin
    pe_try = 1'b0;
    pe_prot = prot_hit(addr_q, sr_q[5:2], top_bottom_select);
    case (op_q)
      `SFR_OP_PAGE_PROG, `SFR_OP_INFO_ROW_PROG:
        pe_try = cyc_q > c_ade;
      `SFR_OP_QUAD_PROG_A, `SFR_OP_QUAD_PROG_B:
        pe_try = !qpi_q && cyc_q > c_ade;
      `SFR_OP_SECT_ERASE_Q, `SFR_OP_SECT_ERASE_S,
      `SFR_OP_BLK32_ERASE, `SFR_OP_BLK64_ERASE, `SFR_OP_INFO_ROW_ERASE:
        pe_try = has_adr;
      `SFR_OP_CHIP_ERASE_A, `SFR_OP_CHIP_ERASE_B:
      begin
        pe_try = only_op;
        pe_prot = sr_q[5:2] != 4'h0;
      end
      default:
        pe_try = 1'b0;
    endcase
    if (op_q == `SFR_OP_INFO_ROW_PROG || op_q == `SFR_OP_INFO_ROW_ERASE)
      pe_prot = 1'b0;
  end

  assign wr_try = pe_try || sr_try || fr_try;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      write_enable_latch <= 1'b0;
    else if (cs_rise && only_op && op_q == `SFR_OP_SET_WRITE_LAT)
      write_enable_latch <= 1'b1;
    else if (cs_rise && ((only_op && op_q == `SFR_OP_CLR_WRITE_LAT) || wr_try))
      write_enable_latch <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      qpi_q <= 1'b0;
    else if (cs_rise && only_op && !qpi_q && op_q == `SFR_OP_QPI_ENTER)
      qpi_q <= 1'b1;
    else if (cs_rise && only_op && qpi_q && op_q == `SFR_OP_QPI_EXIT)
      qpi_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      rp_q <= `SFR_RP_DEFAULT;
    else if (cs_rise && has_dat && op_q == `SFR_OP_SET_READ_PARAM)
      rp_q <= dat_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      sr_q <= `SFR_SR_RESET;
    else if (cs_rise && sr_try && write_enable_latch && !sr_lock)
      sr_q <= {dat_q[7:2], 2'b00};
  end

  // One-time bit: can only be set
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      top_bottom_select <= 1'b0;
    else if (cs_rise && fr_try && write_enable_latch)
      top_bottom_select <= top_bottom_select | dat_q[`SFR_FR_TBS];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pe_req <= 1'b0;
      wr_ignored <= 1'b0;
      pe_op <= 8'h00;
      pe_addr <= 24'h000000;
    end
    else
    begin
      pe_req <= cs_rise && pe_try && write_enable_latch && !pe_prot;
      wr_ignored <= cs_rise && wr_try && (!write_enable_latch ||
                    (pe_try && pe_prot) || (sr_try && sr_lock));
      if (cs_rise && pe_try)
      begin
        pe_op <= op_q;
        pe_addr <= addr_q;
      end
    end
  end

  assign status_write_disable = sr_q[`SFR_SR_STATUS_WRITE_DISABLE];
  assign quad_io_enable = sr_q[`SFR_SR_QE];
  assign protect_level_msb = sr_q[5];
  assign protect_level_low = sr_q[4:2];
  assign qpi_mode = qpi_q;
  assign read_params = rp_q;
  assign drive_eighths = 4'(`SFR_DRIVE_TBL >> {rp_q[7:5], 2'b00});
  assign drive_reserved = rp_q[6:5] == 2'b00;
  assign burst_bytes = `SFR_BURST_MIN << rp_q[1:0];
endmodule

// ---- sfr_cmd_top_asserts.sv ----
// Concurrent checks on the flash command front end top-level ports.
// Assumes every watched port is sampled on the core clock.
`timescale 1ns/1ps
module sfr_cmd_top_asserts
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       cs_b,
  input wire logic [3:0] io_oe,
  input wire logic       pe_req,
  input wire logic       wr_ignored,
  input wire logic       write_enable_latch,
  input wire logic [7:0] read_params,
  input wire logic [3:0] drive_eighths,
  input wire logic       drive_reserved,
  input wire logic [7:0] burst_bytes
);
  // Eighths per drive code, one nibble per code
  localparam logic [31:0] DRV_TBL = 32'h48603210;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_drive_decode: assert property ($stable(read_params) [*2] |->
    drive_eighths == DRV_TBL[{read_params[7:5], 2'b00} +: 4]) else $error("drive strength decode wrong");
  a_drive_resv: assert property ($stable(read_params) [*2] |->
    drive_reserved == (read_params[6:5] == 2'b00)) else $error("reserved drive flag wrong");
  a_burst_len: assert property ($stable(read_params) [*2] |->
    burst_bytes == (8'h08 << read_params[1:0])) else $error("burst length wrong");
  a_oe_idle: assert property (cs_b && $past(cs_b) |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_pe_pulse: assert property (pe_req |=> !pe_req) else $error("program request too long");
  a_ign_pulse: assert property (wr_ignored |=> !wr_ignored) else $error("refusal pulse too long");
  a_one_verdict: assert property (!(pe_req && wr_ignored)) else $error("accepted and refused");
  a_latch_first: assert property (pe_req |-> $past(write_enable_latch, 5))
    else $error("write accepted without latch");
  a_exec_after: assert property (pe_req |-> $past(cs_b, 2)) else $error("executed inside frame");
  c_pe: cover property (pe_req);
  c_ign: cover property (wr_ignored);
  c_resv: cover property (drive_reserved);
endmodule

bind sfr_cmd_top sfr_cmd_top_asserts u_chk
(
  .core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .io_oe(io_oe), .pe_req(pe_req),
  .wr_ignored(wr_ignored), .write_enable_latch(write_enable_latch), .read_params(read_params),
  .drive_eighths(drive_eighths), .drive_reserved(drive_reserved), .burst_bytes(burst_bytes)
);

// ---- sfr_host_model.sv ----
// Behavioural serial flash host: one frame per call, clock idle between.
// Assumes the caller waits out the deselect gap between frames.
`timescale 1ns/1ps
module sfr_host_model
(
  // Link
  output logic            sck,
  output logic            cs_b,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [3:0] oe_s;
  logic [3:0] out_s;
  // Set by the bench while the device is in QPI mode
  bit         qpi;
  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    io_in = 4'h5;
  end
  // Data changes with clock low; lanes are sampled just before the rise.
  // With two set, the low nibble follows on the falling edge.
  task automatic cyc(input logic [7:0] d, input bit two = 1'b0);
    io_in = two ? d[7:4] : d[3:0];
    #15;
    oe_s = io_oe;
    out_s = io_out;
    sck = 1'b1;
    #8;
    if (two)
      io_in = d[3:0];
    #7;
    sck = 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] pay, input int pb, w, dm, rc,
                       output logic [31:0] rd, output int bad);
    bad = 0;
    rd = '0;
    cs_b = 1'b0;
    #10;
    for (int i = 7; i >= 0; i -= qpi ? 4 : 1)
    begin
      cyc(qpi ? op[i -: 4] : {3'h0, op[i]});
      bad += int'(oe_s != 4'h0);
    end
    for (int k = pb - w; k >= 0; k -= w)
    begin
      // Eight bits per clock means four lanes on both edges
      cyc(8'((pay >> k) & ((1 << w) - 1)), w == 8);
      bad += int'(oe_s != 4'h0);
    end
    repeat (dm)
    begin
      cyc(4'h0);
      bad += int'(oe_s != 4'h0);
    end
    for (int k = 0; k < rc; k++)
    begin
      cyc(~io_in);
      if (k == 0)
        bad += int'(oe_s == 4'h0);
      rd = {rd[30:0], out_s[1]};
    end
    cs_b = 1'b1;
    #10;
    io_in = ~io_in;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the flash command front end.
// Assumes the host model drives the link and the array answers combinationally.
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst_b, wp_b, sck, cs_b, pe_req, wr_ignored, write_enable_latch, status_write_disable;
  logic quad_io_enable, protect_level_msb, drive_reserved, qpi_mode, top_bottom_select;
  logic [2:0] protect_level_low;
  logic [3:0] io_in, io_out, io_oe, drive_eighths;
  logic [7:0] rd_byte, pe_op, read_params, burst_bytes, e_sr, e_rp;
  logic [23:0] rd_addr, pe_addr;
  logic [31:0] rd;
  logic [7:0] ops [10] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'h4B, 8'h5A, 8'h68, 8'hBB, 8'hEB, 8'hED};
  logic [7:0] qo [4] = '{8'h0B, 8'hEB, 8'h0D, 8'hED};
  int dt [8] = '{0, 1, 2, 3, 0, 6, 8, 4};
  int qd [4] = '{6, 4, 8, 10};
  int dd [4] = '{3, 2, 4, 5};
  int n_errors, n_checks, n_pe, n_ign, cycles, bad, e_wel, e_ign, e_pe, e_tbs, a, w;
  integer seed;
  assign rd_byte = rd_addr[7:0] ^ 8'hA5;
  sfr_host_model host (.sck(sck), .cs_b(cs_b), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  sfr_cmd_top dut (.core_clk(core_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .wp_b(wp_b), .rd_addr(rd_addr), .rd_byte(rd_byte), .pe_req(pe_req),
    .pe_op(pe_op), .pe_addr(pe_addr), .wr_ignored(wr_ignored), .write_enable_latch(write_enable_latch),
    .status_write_disable(status_write_disable), .quad_io_enable(quad_io_enable),
    .protect_level_msb(protect_level_msb), .protect_level_low(protect_level_low),
    .top_bottom_select(top_bottom_select), .qpi_mode(qpi_mode), .read_params(read_params),
    .drive_eighths(drive_eighths),
    .drive_reserved(drive_reserved), .burst_bytes(burst_bytes));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    n_pe += int'(pe_req === 1'b1);
    n_ign += int'(wr_ignored === 1'b1);
    if (cycles == 30000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Level n protects 2^(n-1) blocks at the top, or at the bottom once selected
  function automatic bit prot(input logic [6:0] blk);
    int n;
    n = int'(e_sr[4:2]);
    return e_sr[5] || (n > 0 && (e_tbs != 0 ? int'(blk) < (1 << (n - 1)) : int'(blk) >= 128 - (1 << (n - 1))));
  endfunction
  task automatic fr(input logic [7:0] op, input logic [31:0] pay, input int pb, w, dm, rc);
    host.frame(op, pay, pb, w, dm, rc, rd, bad);
    repeat (10) @(posedge core_clk);
    if (op == 8'h06)
      e_wel = 1;
    if (op == 8'hC0)
      e_rp = pay[7:0];
    if (op == 8'h01 || op == 8'hD8 || op == 8'h42)
    begin
      if (e_wel == 0 || (op == 8'h01 && e_sr[7] && !wp_b) || (op == 8'hD8 && prot(pay[22:16])))
        e_ign++;
      else if (op == 8'h01)
        e_sr = pay[7:0];
      else if (op == 8'h42)
        e_tbs |= pay[1];
      else
        e_pe++;
      e_wel = 0;
    end
    chk(n_ign, e_ign);
    chk(n_pe, e_pe);
    chk(32'(write_enable_latch), e_wel);
    chk(32'(top_bottom_select), e_tbs);
    chk({status_write_disable, quad_io_enable, protect_level_msb, protect_level_low, 2'b00}, e_sr & 8'hFC);
    chk(read_params, e_rp);
    chk(drive_eighths, dt[e_rp[7:5]]);
    chk(32'(drive_reserved), 32'(dt[e_rp[7:5]] == 0));
    chk(burst_bytes, 8 << e_rp[1:0]);
    chk(bad, 0);
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 0;
    rst_b = 0;
    wp_b = 1;
    seed = 32'hdc1150f1;
    e_sr = 8'h00;
    e_rp = 8'hE0;
    repeat (6) @(posedge core_clk);
    #1 rst_b = 1;
    repeat (4) @(posedge core_clk);
    fr(8'h01, 8'h84, 8, 1, 0, 0);
    fr(8'h06, 0, 0, 1, 0, 0);
    fr(8'h01, 8'h84, 8, 1, 0, 0);
    @(posedge core_clk) #1 wp_b = 0;
    fr(8'h06, 0, 0, 1, 0, 0);
    fr(8'h01, 8'h00, 8, 1, 0, 0);
    @(posedge core_clk) #1 wp_b = 1;
    fr(8'h06, 0, 0, 1, 0, 0);
    fr(8'h01, 8'h44, 8, 1, 0, 0);
    for (int p = 0; p < 3; p++)
    begin
      if (p < 2)
        fr(8'h06, 0, 0, 1, 0, 0);
      fr(8'hD8, p == 0 ? 24'h7F0000 : 24'h000100, 24, 1, 0, 0);
    end
    chk(pe_op, 8'hD8);
    chk(pe_addr, 24'h000100);
    fr(8'h06, 0, 0, 1, 0, 0);
    fr(8'h42, 8'h02, 8, 1, 0, 0);
    fr(8'h06, 0, 0, 1, 0, 0);
    fr(8'hD8, 24'h000100, 24, 1, 0, 0);
    for (int c = 0; c < 8; c++)
      fr(8'hC0, {c[2:0], 5'($random(seed))}, 8, 1, 0, 0);
    foreach (ops[i])
      for (int ds = 0; ds < 4; ds++)
      begin
        w = ops[i] == 8'hBB ? 2 : ops[i] == 8'hEB ? 4 : ops[i] == 8'hED ? 8 : 1;
        a = ops[i] == 8'h03 ? 0 : ops[i] == 8'hEB ? qd[ds] : ops[i] == 8'hED ? dd[ds] :
            ops[i] == 8'hBB ? (ds < 2 ? 4 : 8) : 8;
        fr(8'hC0, 8'hE0 | (ds << 3), 8, 1, 0, 0);
        fr(ops[i], 24'($random(seed)), 24, w, a, 1);
      end
    for (int wr = 1; wr >= 0; wr--)
    begin
      fr(8'hC0, 8'hE0 | (wr << 2), 8, 1, 0, 0);
      fr(8'h03, 24'h000105, 24, 1, 0, 32);
      for (int k = 0; k < 4; k++)
      begin
        a = wr == 1 ? 32'h100 + ((5 + k) & 7) : 32'h105 + k;
        chk(32'(rd[31 - 8 * k -: 8]), (a & 8'hFF) ^ 8'hA5);
      end
    end
    fr(8'h35, 0, 0, 1, 0, 0);
    chk(32'(qpi_mode), 1);
    host.qpi = 1'b1;
    foreach (qo[i])
      for (int ds = 0; ds < 4; ds++)
      begin
        fr(8'hC0, 8'hE0 | (ds << 3), 8, 4, 0, 0);
        fr(qo[i], 24'($random(seed)), 24, i > 1 ? 8 : 4, i > 1 ? dd[ds] : qd[ds], 1);
      end
    fr(8'hF5, 0, 0, 4, 0, 0);
    host.qpi = 1'b0;
    chk(32'(qpi_mode), 0);
    end_of_test();
  end
endmodule
